// ---- rtl/epiu_pkg.sv ----
// Package for the external pin interrupt unit: register offsets, field positions, resets.
// Assumes a 4-bit register port, one word per offset, on a single 250 MHz clock.
package epiu_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [2:0] EPIU_ADDR_CTRL0 = 3'h0;
  localparam logic [2:0] EPIU_ADDR_CTRL1 = 3'h1;
  localparam logic [2:0] EPIU_ADDR_IRQ_EN = 3'h2;
  localparam logic [2:0] EPIU_ADDR_WAKE = 3'h3;
  localparam logic [2:0] EPIU_ADDR_STATUS = 3'h4;
  localparam logic [2:0] EPIU_ADDR_CMD = 3'h5;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int EPIU_BIT_GATE = 3;
  localparam int EPIU_BIT_POL = 2;
  localparam int EPIU_BIT_BOTH = 1;
  localparam int EPIU_BIT_SYNC = 0;
  localparam int EPIU_BIT_EN0 = 0;
  localparam int EPIU_BIT_EN1 = 1;
  localparam int EPIU_BIT_WAKE0 = 0;
  localparam int EPIU_BIT_WAKE1 = 2;
  localparam int EPIU_BIT_FLAG0 = 0;
  localparam int EPIU_BIT_FLAG1 = 1;
  localparam int EPIU_BIT_PDOWN = 2;
  localparam int EPIU_BIT_ARMED = 3;
  // ****************************************
  // Command codes written to the command register
  // ****************************************
  localparam logic [3:0] EPIU_CMD_SKIP0 = 4'h1;
  localparam logic [3:0] EPIU_CMD_SKIP1 = 4'h2;
  localparam logic [3:0] EPIU_CMD_ARM = 4'h3;
  localparam logic [3:0] EPIU_CMD_ENTER = 4'h4;
  localparam logic [3:0] EPIU_CMD_ENTER_ALT = 4'h5;
  localparam logic [3:0] EPIU_CMD_ACK0 = 4'h6;
  localparam logic [3:0] EPIU_CMD_ACK1 = 4'h7;
  localparam logic [3:0] EPIU_CMD_OTHER = 4'h0;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [3:0] EPIU_RST_CTRL = 4'h0;
  localparam logic [3:0] EPIU_RST_EN = 4'h0;
  localparam logic [3:0] EPIU_RST_WAKE = 4'h0;
endpackage : epiu_pkg

// ---- rtl/epiu_sync.sv ----
// Two-stage synchroniser for one pin level.
// Assumes the pin is asynchronous to mclk; reset value is low.
`timescale 1ns/1ps
module epiu_sync
  import epiu_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic pin_in,
  output logic pin_sync
);
  logic meta_q;
  logic sync_q;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end
  assign pin_sync = sync_q;
endmodule : epiu_sync

// ---- rtl/epiu_chan.sv ----
// One pin interrupt channel: gate, polarity, edge mode, request flag.
// Assumes a synchronised pin level and one-cycle clear and accept pulses.
`timescale 1ns/1ps
module epiu_chan
  import epiu_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic pin_lvl,
  input wire logic gate,
  input wire logic pol,
  input wire logic both,
  input wire logic clr,
  output logic flag,
  output logic wake_lvl
);
  logic sig_q;
  logic flag_q;
  logic sig_d;
  logic rise;
  logic fall;
  logic hit;
  // Gated-off input reads low; gate or polarity changes make edges here
  assign sig_d = gate & (pin_lvl ^ ~pol);
  assign rise = sig_d & ~sig_q;
  assign fall = ~sig_d & sig_q;
  assign hit = rise | (both & fall);
  assign wake_lvl = sig_d;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sig_q <= 1'b0;
      flag_q <= 1'b0;
    end
    else
    begin
      sig_q <= sig_d;
      // Set wins over a clear in the same cycle
      flag_q <= hit | (flag_q & ~clr);
    end
  end
  assign flag = flag_q;
endmodule : epiu_chan

// ---- rtl/epiu_top.sv ----
// Top of the external pin interrupt unit: registers, skip tests, power down.
// Assumes a core that issues commands through the register port, one per cycle.
// Operation
// - Gate toggle on pin 0 may set flag
// - Polarity change on pin 0 may set flag
// - Gate toggle on pin 1 may set flag
// - Polarity change on pin 1 may set flag
// - Skip test 0 clears flag, skips if set
// - Skip test 1 clears flag, skips if set
// - Power down only right after arming
// - Gate bit blocks at 0, resets 0
// - Polarity 0 falling/low, 1 rising/high
// - Edge bit 0 one edge, 1 both
// - Enabled irq taken, skip test then ignored
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
module epiu_top
  import epiu_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [2:0] reg_addr,
  input wire logic [3:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [3:0] reg_rdata,
  input wire logic pin_irq_zero,
  input wire logic pin_irq_one,
  output logic irq_req0,
  output logic irq_req1,
  output logic skip_next,
  output logic power_down,
  output logic wake_up
);
  // ****************************************
  // Registers
  // ****************************************
  logic [3:0] pin0_control_reg_q;
  logic [3:0] pin1_control_reg_q;
  logic [3:0] irq_enable_reg_a_q;
  logic [3:0] wake_en_q;
  logic [3:0] rdata_q;
  logic armed_q;
  logic pdown_q;
  logic skip_q;
  logic wake_q;
  logic req0_q;
  logic req1_q;
  logic pin0_s;
  logic pin1_s;
  logic pin0_request_flag;
  logic pin1_request_flag;
  logic wake0_lvl;
  logic wake1_lvl;
  // ****************************************
  // Decode
  // ****************************************
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic wr_en;
  logic wr_wake;
  logic wr_cmd;
  logic skip_test_pin0;
  logic skip_test_pin1;
  logic power_down_arm;
  logic power_down_enter;
  logic power_down_enter_alt;
  logic ack0;
  logic ack1;
  logic en0;
  logic en1;
  logic clr0;
  logic clr1;
  logic skip_d;
  logic enter_ok;
  logic wake_hit;
  logic [3:0] status;
  logic [3:0] rdata_d;
  logic [3:0] rdata_sel;
  logic [3:0] pin0_control_reg_d;
  logic [3:0] pin1_control_reg_d;
  logic [3:0] irq_enable_reg_a_d;
  logic [3:0] wake_en_d;
  logic armed_d;
  logic pdown_d;
  logic wake_d;
  logic req0_d;
  logic req1_d;
  assign wr_ctrl0 = reg_wr & (reg_addr == EPIU_ADDR_CTRL0);
  assign wr_ctrl1 = reg_wr & (reg_addr == EPIU_ADDR_CTRL1);
  assign wr_en = reg_wr & (reg_addr == EPIU_ADDR_IRQ_EN);
  assign wr_wake = reg_wr & (reg_addr == EPIU_ADDR_WAKE);
  assign wr_cmd = reg_wr & (reg_addr == EPIU_ADDR_CMD);
  assign skip_test_pin0 = wr_cmd & (reg_wdata == EPIU_CMD_SKIP0);
  assign skip_test_pin1 = wr_cmd & (reg_wdata == EPIU_CMD_SKIP1);
  assign power_down_arm = wr_cmd & (reg_wdata == EPIU_CMD_ARM);
  assign power_down_enter = wr_cmd & (reg_wdata == EPIU_CMD_ENTER);
  assign power_down_enter_alt = wr_cmd & (reg_wdata == EPIU_CMD_ENTER_ALT);
  assign ack0 = wr_cmd & (reg_wdata == EPIU_CMD_ACK0);
  assign ack1 = wr_cmd & (reg_wdata == EPIU_CMD_ACK1);
  assign en0 = irq_enable_reg_a_q[EPIU_BIT_EN0];
  assign en1 = irq_enable_reg_a_q[EPIU_BIT_EN1];
  // Skip test only acts with the interrupt disabled
  assign clr0 = (skip_test_pin0 & ~en0) | (ack0 & en0);
  assign clr1 = (skip_test_pin1 & ~en1) | (ack1 & en1);
  assign skip_d = (skip_test_pin0 & ~en0 & pin0_request_flag)
    | (skip_test_pin1 & ~en1 & pin1_request_flag);
  // Any other write to the command port drops the arming
  assign enter_ok = armed_q & (power_down_enter | power_down_enter_alt);
  assign wake_hit = (wake0_lvl & wake_en_q[EPIU_BIT_WAKE0])
    | (wake1_lvl & wake_en_q[EPIU_BIT_WAKE1]);
  assign status = {armed_q, pdown_q, pin1_request_flag, pin0_request_flag};
  assign rdata_sel = (reg_addr == EPIU_ADDR_CTRL0) ? pin0_control_reg_q :
    (reg_addr == EPIU_ADDR_CTRL1) ? pin1_control_reg_q :
    (reg_addr == EPIU_ADDR_IRQ_EN) ? irq_enable_reg_a_q :
    (reg_addr == EPIU_ADDR_WAKE) ? wake_en_q :
    (reg_addr == EPIU_ADDR_STATUS) ? status : 4'h0;
  // ****************************************
  // Pin channels
  // ****************************************
  epiu_sync u_sync0 (
    .mclk(mclk),
    .rst_b(rst_b),
    .pin_in(pin_irq_zero),
    .pin_sync(pin0_s)
  );
  epiu_sync u_sync1 (
    .mclk(mclk),
    .rst_b(rst_b),
    .pin_in(pin_irq_one),
    .pin_sync(pin1_s)
  );
  epiu_chan u_chan0 (
    .mclk(mclk),
    .rst_b(rst_b),
    .pin_lvl(pin0_s),
    .gate(pin0_control_reg_q[EPIU_BIT_GATE]),
    .pol(pin0_control_reg_q[EPIU_BIT_POL]),
    .both(pin0_control_reg_q[EPIU_BIT_BOTH]),
    .clr(clr0),
    .flag(pin0_request_flag),
    .wake_lvl(wake0_lvl)
  );
  epiu_chan u_chan1 (
    .mclk(mclk),
    .rst_b(rst_b),
    .pin_lvl(pin1_s),
    .gate(pin1_control_reg_q[EPIU_BIT_GATE]),
    .pol(pin1_control_reg_q[EPIU_BIT_POL]),
    .both(pin1_control_reg_q[EPIU_BIT_BOTH]),
    .clr(clr1),
    .flag(pin1_request_flag),
    .wake_lvl(wake1_lvl)
  );
  // ****************************************
  // Next values
  // ****************************************
  assign pin0_control_reg_d = wr_ctrl0 ? reg_wdata : pin0_control_reg_q;
  assign pin1_control_reg_d = wr_ctrl1 ? reg_wdata : pin1_control_reg_q;
  assign irq_enable_reg_a_d = wr_en ? reg_wdata : irq_enable_reg_a_q;
  assign wake_en_d = wr_wake ? reg_wdata : wake_en_q;
  // Zero outside its slot, so read data can be ORed onto a shared bus
  assign rdata_d = reg_rd ? rdata_sel : 4'h0;
  assign armed_d = wr_cmd ? power_down_arm : armed_q;
  // Entry beats a wake level seen in the same cycle
  assign pdown_d = enter_ok | (pdown_q & ~wake_hit);
  assign wake_d = pdown_q & wake_hit;
  // Request stays high until the core acknowledges or clears the enable bit
  assign req0_d = pin0_request_flag & en0 & ~clr0;
  assign req1_d = pin1_request_flag & en1 & ~clr1;
  // ****************************************
  // Register file
  // ****************************************
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin0_control_reg_q <= EPIU_RST_CTRL;
    end
    else
    begin
      pin0_control_reg_q <= pin0_control_reg_d;
    end
  end
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin1_control_reg_q <= EPIU_RST_CTRL;
    end
    else
    begin
      pin1_control_reg_q <= pin1_control_reg_d;
    end
  end
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_enable_reg_a_q <= EPIU_RST_EN;
    end
    else
    begin
      irq_enable_reg_a_q <= irq_enable_reg_a_d;
    end
  end
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wake_en_q <= EPIU_RST_WAKE;
    end
    else
    begin
      wake_en_q <= wake_en_d;
    end
  end
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata_q <= 4'h0;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end
  // ****************************************
  // Skip, power down and request outputs
  // ****************************************
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      armed_q <= 1'b0;
    end
    else
    begin
      armed_q <= armed_d;
    end
  end
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pdown_q <= 1'b0;
    end
    else
    begin
      pdown_q <= pdown_d;
    end
  end
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      skip_q <= 1'b0;
    end
    else
    begin
      skip_q <= skip_d;
    end
  end
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wake_q <= 1'b0;
    end
    else
    begin
      wake_q <= wake_d;
    end
  end
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      req0_q <= 1'b0;
    end
    else
    begin
      req0_q <= req0_d;
    end
  end
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      req1_q <= 1'b0;
    end
    else
    begin
      req1_q <= req1_d;
    end
  end
  assign reg_rdata = rdata_q;
  assign irq_req0 = req0_q;
  assign irq_req1 = req1_q;
  assign skip_next = skip_q;
  assign power_down = pdown_q;
  assign wake_up = wake_q;
endmodule : epiu_top

// ---- sim/epiu_sva.sv ----
// Checker on the top ports of the pin interrupt unit.
// Assumes one clock domain and the command codes of the package.
`timescale 1ns/1ps
module epiu_sva
  import epiu_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [2:0] reg_addr,
  input wire logic [3:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_rdata,
  input wire logic irq_req0,
  input wire logic irq_req1,
  input wire logic skip_next,
  input wire logic power_down,
  input wire logic wake_up
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire cmd_wr = reg_wr && (reg_addr == EPIU_ADDR_CMD);
  wire enter_wr = cmd_wr && (reg_wdata inside {EPIU_CMD_ENTER, EPIU_CMD_ENTER_ALT});
  wire skip_wr = cmd_wr && (reg_wdata inside {EPIU_CMD_SKIP0, EPIU_CMD_SKIP1});
  sequence s_arm; cmd_wr && (reg_wdata == EPIU_CMD_ARM); endsequence
  sequence s_enter; enter_wr; endsequence
  property p_rdata_idle; !reg_rd |=> reg_rdata == 4'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside its slot");
  property p_pd_entry; s_arm ##1 !cmd_wr ##1 s_enter |=> power_down; endproperty
  a_pd_entry: assert property (p_pd_entry)
    else $error("no power down after arm and enter");
  property p_pd_cause; $rose(power_down) |-> $past(enter_wr); endproperty
  a_pd_cause: assert property (p_pd_cause)
    else $error("power down without enter");
  property p_skip_cause; skip_next |-> $past(skip_wr); endproperty
  a_skip_cause: assert property (p_skip_cause)
    else $error("skip without skip test");
  property p_pd_exit; $fell(power_down) |-> wake_up || $past(wake_up); endproperty
  a_pd_exit: assert property (p_pd_exit)
    else $error("power down left without wake");
  property p_wake_in_pd; wake_up |-> $past(power_down); endproperty
  a_wake_in_pd: assert property (p_wake_in_pd)
    else $error("wake outside power down");
  property p_accept0; cmd_wr && reg_wdata == EPIU_CMD_ACK0 |-> ##2 !irq_req0; endproperty
  a_accept0: assert property (p_accept0)
    else $error("request 0 kept after accept");
  property p_accept1; cmd_wr && reg_wdata == EPIU_CMD_ACK1 |-> ##2 !irq_req1; endproperty
  a_accept1: assert property (p_accept1)
    else $error("request 1 kept after accept");
endmodule : epiu_sva

// ---- sim/epiu_pin_src.sv ----
// Outside circuit driving both interrupt pins.
// Assumes level requests from the bench; pins always driven.
`timescale 1ns/1ps
module epiu_pin_src (
  input wire logic [1:0] lvl,
  output logic pin_irq_zero,
  output logic pin_irq_one
);
  // Skew keeps pin edges off the clock grid
  // Continuous, so the pins follow the first level set at time zero
  assign #1.3 {pin_irq_one, pin_irq_zero} = lvl;
endmodule : epiu_pin_src

// ---- sim/epiu_top_tb.sv ----
// Self-checking bench for the pin interrupt unit.
// Assumes the register map and command codes of the package.
`timescale 1ns/1ps
module epiu_top_tb;
  import epiu_pkg::*;
  logic mclk, rst_b, reg_wr, reg_rd, rd_d, sk_d, pin0, pin1, irq0, irq1, skip_next;
  logic power_down, wake_up;
  logic [2:0] reg_addr;
  logic [3:0] reg_wdata, reg_rdata;
  logic [1:0] lvl;
  logic [3:0] rq[$], sq[$];
  int mismatches, cmp_count;
  epiu_pin_src src (.lvl(lvl), .pin_irq_zero(pin0), .pin_irq_one(pin1));
  epiu_top dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_irq_zero(pin0),
    .pin_irq_one(pin1), .irq_req0(irq0), .irq_req1(irq1), .skip_next(skip_next),
    .power_down(power_down), .wake_up(wake_up));
  // ****
  // Bus tasks and checks
  // ****
  task automatic chk(string what, logic [3:0] exp, logic [3:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(logic [2:0] a, logic [3:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [2:0] a, logic [3:0] e);
    rq.push_back(e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic skip(int ch, logic e);
    sq.push_back({3'h0, e});
    wr(EPIU_ADDR_CMD, ch ? EPIU_CMD_SKIP1 : EPIU_CMD_SKIP0);
  endtask : skip
  task automatic summarize();
    if (mismatches == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  // Results land one cycle after their strobe
  always @(negedge mclk)
  begin
    if (rd_d)
      chk("reg_rdata", rq.pop_front(), reg_rdata);
    if (sk_d)
      chk("skip_next", sq.pop_front(), {3'h0, skip_next});
    rd_d = reg_rd;
    sk_d = reg_wr && reg_addr == EPIU_ADDR_CMD
      && reg_wdata inside {EPIU_CMD_SKIP0, EPIU_CMD_SKIP1};
  end
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    #20000;
    mismatches++;
    summarize();
  end
  // ****
  // Main sequence
  // ****
  initial
  begin
    int ch;
    logic p, b;
    logic [2:0] ca;
    logic [3:0] c;
    void'($urandom(32'hf46e));
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    lvl = 2'b11;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    for (int a = 0; a < 5; a++) rd(3'(a), 4'h0);
    rd(3'h6, 4'h0);
    for (int i = 0; i < 8; i++)
    begin
      ch = i / 4;
      {p, b} = 2'(i);
      ca = ch ? EPIU_ADDR_CTRL1 : EPIU_ADDR_CTRL0;
      wr(ca, 4'h0);
      lvl[ch] <= ~p;
      if (ch == 0)
        lvl[1] <= 1'($urandom);
      repeat (4) @(posedge mclk);
      wr(ca, {1'b1, p, b, 1'b0});
      repeat ($urandom_range(6, 3)) @(posedge mclk);
      skip(ch, 1'b0);
      lvl[ch] <= p;
      repeat (6) @(posedge mclk);
      skip(ch, 1'b1);
      skip(ch, 1'b0);
      lvl[ch] <= ~p;
      repeat (6) @(posedge mclk);
      skip(ch, b);
    end
    for (ch = 0; ch < 2; ch++)
    begin
      ca = ch ? EPIU_ADDR_CTRL1 : EPIU_ADDR_CTRL0;
      wr(ca, 4'h4);
      lvl[ch] <= 1'b1;
      repeat (4) @(posedge mclk);
      wr(ca, 4'hc);
      repeat (3) @(posedge mclk);
      skip(ch, 1'b1);
      lvl[ch] <= 1'b0;
      repeat (6) @(posedge mclk);
      wr(ca, 4'h8);
      repeat (3) @(posedge mclk);
      skip(ch, 1'b1);
    end
    wr(EPIU_ADDR_IRQ_EN, 4'h3);
    lvl <= 2'b11;
    repeat (6) @(posedge mclk);
    lvl <= 2'b00;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    chk("irq_req", 4'h3, {2'h0, irq1, irq0});
    skip(0, 1'b0);
    skip(1, 1'b0);
    rd(EPIU_ADDR_STATUS, 4'h3);
    wr(EPIU_ADDR_CMD, EPIU_CMD_ACK0);
    wr(EPIU_ADDR_CMD, EPIU_CMD_ACK1);
    rd(EPIU_ADDR_STATUS, 4'h0);
    wr(EPIU_ADDR_IRQ_EN, 4'h0);
    wr(EPIU_ADDR_WAKE, 4'h0);
    lvl <= 2'b11;
    for (int k = 0; k < 2; k++)
    begin
      c = k ? EPIU_CMD_ENTER_ALT : EPIU_CMD_ENTER;
      wr(EPIU_ADDR_CMD, EPIU_CMD_ARM);
      wr(EPIU_ADDR_CMD, EPIU_CMD_OTHER);
      wr(EPIU_ADDR_CMD, c);
      @(negedge mclk);
      chk("power_down", 4'h0, {3'h0, power_down});
      wr(EPIU_ADDR_CMD, EPIU_CMD_ARM);
      wr(EPIU_ADDR_CMD, c);
      @(negedge mclk);
      chk("power_down", 4'h1, {3'h0, power_down});
      wr(EPIU_ADDR_WAKE, k ? 4'h4 : 4'h1);
      lvl[k] <= 1'b0;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk("wake_up", 4'h1, {3'h0, wake_up});
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk("wake_up", 4'h0, {3'h0, wake_up});
      chk("power_down", 4'h0, {3'h0, power_down});
      lvl[k] <= 1'b1;
      wr(EPIU_ADDR_WAKE, 4'h0);
    end
    repeat (3) @(posedge mclk);
    summarize();
  end
endmodule : epiu_top_tb
bind epiu_top epiu_sva u_sva (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq_req0(irq_req0), .irq_req1(irq_req1), .skip_next(skip_next),
  .power_down(power_down), .wake_up(wake_up));
